// *** viu_vectored_irq.v ***
// Vectored interrupt unit with APB register access and core handshake
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "viu_defs.vh"
module viu_vectored_irq (
	clk,
	rst_n,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	reset_req_n,
	pin_one_irq,
	pin_two_irq,
	pin_three_irq,
	pin_four_irq,
	shared_ext_uart_irq_pin,
	configurable_irq_pin,
	timer_ovf,
	uart_irq,
	uart_rx_irq_enable,
	uart_tx_irq_enable,
	instr_done,
	low_power,
	isr_exit_restore_op,
	plain_pop_op,
	pc_in,
	vec_data,
	vec_valid,
	take_irq,
	reset_take,
	push_pc,
	push_addr,
	vec_fetch,
	vec_addr,
	pc_load,
	pc_out,
	pop_req,
	pop_addr,
	port_ab_oe,
	port_p_out,
	global_irq_enable,
	saved_global_enable
);
	input  wire        clk;
	input  wire        rst_n;
	input  wire        psel;
	input  wire        penable;
	input  wire        pwrite;
	input  wire [7:0]  paddr;
	input  wire [31:0] pwdata;
	output reg  [31:0] prdata;
	output reg         pready;
	output reg         pslverr;
	input  wire        reset_req_n;
	input  wire        pin_one_irq;
	input  wire        pin_two_irq;
	input  wire        pin_three_irq;
	input  wire        pin_four_irq;
	input  wire        shared_ext_uart_irq_pin;
	input  wire        configurable_irq_pin;
	input  wire        timer_ovf;
	input  wire        uart_irq;
	input  wire        uart_rx_irq_enable;
	input  wire        uart_tx_irq_enable;
	input  wire        instr_done;
	input  wire        low_power;
	input  wire        isr_exit_restore_op;
	input  wire        plain_pop_op;
	input  wire [15:0] pc_in;
	input  wire [15:0] vec_data;
	input  wire        vec_valid;
	output reg         take_irq;
	output reg         reset_take;
	output reg         push_pc;
	output reg  [15:0] push_addr;
	output reg         vec_fetch;
	output reg  [15:0] vec_addr;
	output reg         pc_load;
	output reg  [15:0] pc_out;
	output reg         pop_req;
	output reg  [15:0] pop_addr;
	output reg         port_ab_oe;
	output reg         port_p_out;
	output reg         global_irq_enable;
	output reg         saved_global_enable;

	localparam ST_IDLE  = 2'd0;
	localparam ST_PUSH  = 2'd1;
	localparam ST_FETCH = 2'd2;
	localparam ST_LOAD  = 2'd3;

	// Vector word address for a rank, counting down from the top
	function [15:0] vec_of;
		input [2:0] rank;
		begin
			vec_of = `VIU_VEC_TOP - {12'h000, rank, 1'b0};
		end
	endfunction

	// Two-stage synchronisers for every pin-side input
	wire [7:0] raw_in = {configurable_irq_pin, shared_ext_uart_irq_pin,
		timer_ovf, pin_four_irq, pin_three_irq, pin_two_irq,
		pin_one_irq, reset_req_n};
	reg  [7:0] sync1_reg;
	reg  [7:0] sync2_reg;
	reg  [7:0] prev_reg;
	reg  [2:0] arm_reg;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 8'hff;
			sync2_reg <= 8'hff;
			prev_reg  <= 8'hff;
			arm_reg   <= 3'b000;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			arm_reg   <= {arm_reg[1:0], 1'b1};
		end
	end

	reg  [7:0]  irq_enable_reg;
	reg  [7:0]  irq_pending_reg;
	reg  [2:0]  irq_edge_select_reg;
	reg  [1:0]  capture_pin_config_reg;
	reg  [15:0] sp_reg;
	reg  [1:0]  state_reg;
	reg  [2:0]  rank_reg;

	// No edges until the chain holds real pin samples: no false edge
	wire [7:0] rise = sync2_reg & ~prev_reg & {8{arm_reg[2]}};
	wire [7:0] fall = ~sync2_reg & prev_reg & {8{arm_reg[2]}};

	// Edge pins: bit set selects rising, clear selects falling
	wire [2:0] edge_hit;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_edge
			assign edge_hit[g] = irq_edge_select_reg[g] ?
				rise[g+2] : fall[g+2];
		end
	endgenerate

	reg cfg_hit;
	always @* begin
		case (capture_pin_config_reg)
			`VIU_CFG_RISE: cfg_hit = rise[7];
			`VIU_CFG_FALL: cfg_hit = fall[7];
			`VIU_CFG_HIGH: cfg_hit = sync2_reg[7];
			`VIU_CFG_LOW:  cfg_hit = ~sync2_reg[7];
			default:       cfg_hit = 1'b0;
		endcase
	end

	// Shared vector: pin is level low; UART request counts only when enabled
	wire uart_on = uart_rx_irq_enable | uart_tx_irq_enable;
	wire shared_hit = ~sync2_reg[6] | (uart_irq & uart_on);
	// Reset level low; timer overflow is an edge
	wire [7:0] trig = {cfg_hit, shared_hit, rise[5], edge_hit,
		rise[1], ~sync2_reg[0]};

	// Maskable requests need own enable and global enable
	wire [7:0] masked = {irq_pending_reg[7:2] & irq_enable_reg[7:2] &
		{6{global_irq_enable}}, irq_pending_reg[1], 1'b0};

	reg [2:0] win;
	reg       any;
	integer   i;
	always @* begin
		win = 3'd0;
		any = 1'b0;
		for (i = 7; i >= 1; i = i - 1) begin
			if (masked[i]) begin
				win = i[2:0];
				any = 1'b1;
			end
		end
	end

	wire reset_now = ~sync2_reg[0];
	wire setup = psel & ~penable;
	// Writes land in the access cycle, when pready is seen high
	wire wr = psel & penable & pready & pwrite;
	wire wr_bad = (paddr > `VIU_OFF_STATUS) | (paddr[1:0] != 2'b00);
	wire start = (state_reg == ST_IDLE) & any & instr_done & ~low_power;
	wire pend_wr = wr & (paddr == `VIU_OFF_PENDING);

	// Pending bits; a new trigger wins over a clear in the same cycle
	reg [7:0] pend_next;
	always @* begin
		pend_next = irq_pending_reg;
		if (pend_wr) begin
			// NMI read-only; edge pins accept zeros only
			pend_next[4:2] = irq_pending_reg[4:2] & pwdata[4:2];
			pend_next[7:5] = pwdata[7:5];
		end
		if (start && win != `VIU_SRC_TIMER && win != `VIU_SRC_SHARED)
			pend_next[win] = 1'b0;
		pend_next = pend_next | trig;
		pend_next[0] = reset_now;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_pending_reg <= 8'h00;
		end else begin
			irq_pending_reg <= pend_next;
		end
	end

	// Registers, acknowledge sequence and bus slave
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_reg         <= `VIU_RST_ENABLE;
			irq_edge_select_reg    <= `VIU_RST_EDGESEL;
			capture_pin_config_reg <= `VIU_RST_CFGPIN;
			global_irq_enable      <= 1'b0;
			saved_global_enable    <= 1'b0;
			sp_reg      <= `VIU_SP_RESET;
			state_reg   <= ST_FETCH;
			rank_reg    <= 3'd0;
			take_irq    <= 1'b0;
			reset_take  <= 1'b1;
			push_pc     <= 1'b0;
			push_addr   <= 16'h0000;
			// Leaving reset starts with the reset vector fetch
			vec_fetch   <= 1'b1;
			vec_addr    <= `VIU_VEC_TOP;
			pc_load     <= 1'b0;
			pc_out      <= 16'h0000;
			pop_req     <= 1'b0;
			pop_addr    <= 16'h0000;
			port_ab_oe  <= 1'b0;
			port_p_out  <= 1'b0;
			prdata      <= 32'h00000000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
		end else begin
			take_irq <= 1'b0;
			push_pc  <= 1'b0;
			pc_load  <= 1'b0;
			pop_req  <= 1'b0;
			pready   <= setup;
			pslverr  <= 1'b0;
			reset_take <= 1'b0;
			if (wr) begin
				case (paddr)
					`VIU_OFF_ENABLE: begin
						irq_enable_reg    <= pwdata[7:0];
						global_irq_enable <= pwdata[`VIU_BIT_GIE];
					end
					`VIU_OFF_EDGESEL: irq_edge_select_reg <= pwdata[2:0];
					`VIU_OFF_CFGPIN: capture_pin_config_reg <= pwdata[1:0];
					`VIU_OFF_STATUS:
						saved_global_enable <= pwdata[`VIU_BIT_SAVED_GLOBAL_ENABLE];
					`VIU_OFF_PENDING: ;
					default: ;
				endcase
			end
			// Error is decided in setup so that it stands with pready
			if (setup && pwrite && wr_bad)
				pslverr <= 1'b1;
			if (setup && !pwrite) begin
				case (paddr)
					`VIU_OFF_ENABLE: prdata <= {24'h0,
						irq_enable_reg[7:1], global_irq_enable};
					`VIU_OFF_PENDING: prdata <= {24'h0, irq_pending_reg};
					`VIU_OFF_EDGESEL: prdata <= {29'h0, irq_edge_select_reg};
					`VIU_OFF_CFGPIN: prdata <= {30'h0, capture_pin_config_reg};
					`VIU_OFF_STATUS: prdata <= {31'h0, saved_global_enable};
					`VIU_OFF_SP: prdata <= {16'h0, sp_reg};
					`VIU_OFF_VECTOR: prdata <= {16'h0, vec_addr};
					default: begin
						prdata  <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
			if (reset_now) begin
				// Reset acts without waiting for the instruction
				port_ab_oe  <= 1'b0;
				port_p_out  <= 1'b0;
				reset_take  <= 1'b1;
				vec_fetch   <= 1'b1;
				vec_addr    <= vec_of(3'd0);
				rank_reg    <= 3'd0;
				sp_reg      <= `VIU_SP_RESET;
				global_irq_enable <= 1'b0;
				state_reg   <= ST_FETCH;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						if (start) begin
							rank_reg  <= win;
							take_irq  <= 1'b1;
							state_reg <= ST_PUSH;
						end else if (isr_exit_restore_op) begin
							pop_req  <= 1'b1;
							pop_addr <= sp_reg - 16'h0002;
							sp_reg   <= sp_reg - 16'h0002;
							if (saved_global_enable)
								global_irq_enable <= 1'b1;
						end else if (plain_pop_op) begin
							pop_req  <= 1'b1;
							pop_addr <= sp_reg - 16'h0002;
							sp_reg   <= sp_reg - 16'h0002;
						end
					end
					ST_PUSH: begin
						push_pc   <= 1'b1;
						push_addr <= sp_reg;
						sp_reg    <= sp_reg + 16'h0002;
						saved_global_enable <= global_irq_enable;
						global_irq_enable   <= 1'b0;
						vec_fetch <= 1'b1;
						vec_addr  <= vec_of(rank_reg);
						state_reg <= ST_FETCH;
					end
					ST_FETCH: begin
						if (vec_valid) begin
							vec_fetch <= 1'b0;
							pc_out    <= vec_data;
							state_reg <= ST_LOAD;
						end
					end
					ST_LOAD: begin
						pc_load   <= 1'b1;
						state_reg <= ST_IDLE;
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// *** viu_defs.vh ***
// Constants for the vectored interrupt unit
`ifndef VIU_DEFS_VH
`define VIU_DEFS_VH
`define VIU_OFF_ENABLE   8'h00
`define VIU_OFF_PENDING  8'h04
`define VIU_OFF_EDGESEL  8'h08
`define VIU_OFF_CFGPIN   8'h0c
`define VIU_OFF_STATUS   8'h10
`define VIU_OFF_SP       8'h14
`define VIU_OFF_VECTOR   8'h18
`define VIU_BIT_GIE      0
`define VIU_BIT_SAVED_GLOBAL_ENABLE     0
`define VIU_VEC_TOP      16'hfffe
`define VIU_SP_RESET     16'h0100
`define VIU_RST_ENABLE   8'h00
`define VIU_RST_EDGESEL  3'h0
`define VIU_RST_CFGPIN   2'h0
`define VIU_CFG_RISE     2'h0
`define VIU_CFG_FALL     2'h1
`define VIU_CFG_HIGH     2'h2
`define VIU_CFG_LOW      2'h3
`define VIU_SRC_RESET    0
`define VIU_SRC_NMI      1
`define VIU_SRC_TIMER    5
`define VIU_SRC_SHARED   6
`define VIU_SRC_CFG      7
`endif

// *** viu_core_model.sv ***
// Core memory model that answers vector fetches
`timescale 1ns/100ps
module viu_core_model (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        slow,
	input wire logic        vec_fetch,
	input wire logic [15:0] vec_addr,
	output logic            vec_valid,
	output logic [15:0]     vec_data
);
	logic [1:0] wait_cnt;
	// Released data toggles so a stale word never looks valid
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_valid <= 1'b0;
			vec_data <= 16'h0000;
			wait_cnt <= 2'h0;
		end else if (vec_fetch && !vec_valid && (!slow || wait_cnt == 2'h3)) begin
			vec_valid <= 1'b1;
			vec_data <= {4'hc, vec_addr[11:0]};
			wait_cnt <= 2'h0;
		end else begin
			vec_valid <= 1'b0;
			vec_data <= ~vec_data;
			wait_cnt <= vec_fetch ? wait_cnt + 2'h1 : 2'h0;
		end
	end
endmodule

// *** viu_monitor.sv ***
// Assertion checker for the vectored interrupt unit
`timescale 1ns/100ps
module viu_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        instr_done,
	input wire logic        low_power,
	input wire logic        isr_exit_restore_op,
	input wire logic [15:0] vec_data,
	input wire logic        vec_valid,
	input wire logic        take_irq,
	input wire logic        push_pc,
	input wire logic        vec_fetch,
	input wire logic [15:0] vec_addr,
	input wire logic        pc_load,
	input wire logic [15:0] pc_out,
	input wire logic        pop_req,
	input wire logic        global_irq_enable,
	input wire logic        saved_global_enable
);
	logic [15:0] last_vec;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			last_vec <= 16'h0000;
		else if (vec_valid)
			last_vec <= vec_data;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_VEC_RANGE: assert property (vec_fetch |->
		vec_addr[15:4] == 12'hfff && !vec_addr[0]) else $error("bad vector");
	AST_TAKE_GATE: assert property (take_irq |->
		$past(instr_done) && !$past(low_power)) else $error("early take");
	AST_PUSH: assert property (take_irq |=> push_pc)
		else $error("no push");
	AST_SAVE: assert property (take_irq |-> ##3
		saved_global_enable == $past(global_irq_enable, 3) &&
		!global_irq_enable) else $error("enable not saved");
	AST_FETCH_HOLD: assert property (vec_fetch && !vec_valid |=>
		vec_fetch && $stable(vec_addr)) else $error("fetch dropped");
	AST_PC_VALUE: assert property (pc_load |-> pc_out == last_vec)
		else $error("wrong pc");
	AST_POP: assert property (isr_exit_restore_op |=> pop_req)
		else $error("no pop");
	AST_RESTORE: assert property (isr_exit_restore_op &&
		saved_global_enable |-> ##[1:2] global_irq_enable)
		else $error("enable not restored");
	cover property (take_irq);
	cover property (pop_req);
	cover property (vec_valid && vec_fetch);
endmodule
bind viu_vectored_irq viu_monitor u_viu_monitor (.clk, .rst_n, .instr_done,
	.low_power, .isr_exit_restore_op, .vec_data, .vec_valid, .take_irq,
	.push_pc, .vec_fetch, .vec_addr, .pc_load, .pc_out, .pop_req,
	.global_irq_enable, .saved_global_enable);

// *** tb.sv ***
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err, vec_valid, take_irq, reset_take, push_pc;
	logic reset_req_n = 1, pin_one_irq = 0, pin_two_irq = 0, pin_three_irq = 0;
	logic pin_four_irq = 0, shared_ext_uart_irq_pin = 1, timer_ovf = 0;
	logic configurable_irq_pin = 0, instr_done = 0, low_power = 0;
	logic isr_exit_restore_op = 0, plain_pop_op = 0, vec_fetch, pc_load;
	logic [15:0] vec_data, vec_addr, pc_out;
	logic pop_req, port_ab_oe, port_p_out, global_irq_enable;
	logic saved_global_enable;
	logic uart_irq = 0, uart_rx_irq_enable = 0, uart_tx_irq_enable = 0;
	logic [15:0] push_addr, pop_addr, last_push = 0, last_pop = 0;
	int n_errors = 0, n_compared = 0, loads = 0;
	viu_vectored_irq u_viu_vectored_irq (.clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_req_n,
		.pin_one_irq, .pin_two_irq, .pin_three_irq, .pin_four_irq,
		.shared_ext_uart_irq_pin, .configurable_irq_pin, .timer_ovf,
		.uart_irq, .uart_rx_irq_enable, .uart_tx_irq_enable,
		.instr_done, .low_power, .isr_exit_restore_op, .plain_pop_op,
		.pc_in(16'h0000), .vec_data, .vec_valid, .take_irq, .reset_take,
		.push_pc, .push_addr, .vec_fetch, .vec_addr, .pc_load, .pc_out,
		.pop_req, .pop_addr, .port_ab_oe, .port_p_out, .global_irq_enable,
		.saved_global_enable);
	viu_core_model u_viu_core_model (.clk, .rst_n, .slow, .vec_fetch,
		.vec_addr, .vec_valid, .vec_data);
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (pc_load === 1'b1) loads++;
		if (push_pc === 1'b1) last_push <= push_addr;
		if (pop_req === 1'b1) last_pop <= pop_addr;
	end
	task automatic finish_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Request held from setup until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin n_errors++; finish_test(); end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic wait_load(input logic [15:0] e);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			if (pc_load === 1'b1) break;
		end
		if (i == 300) begin n_errors++; finish_test(); end
		`CHK(pc_out, e)
		@(posedge clk);
	endtask
	task automatic pins(input logic [2:0] v);
		{pin_two_irq, pin_three_irq, pin_four_irq} <= v;
		tick(4);
	endtask
	task automatic pop(input logic restore);
		isr_exit_restore_op <= restore;
		plain_pop_op <= !restore;
		@(posedge clk);
		isr_exit_restore_op <= 0;
		plain_pop_op <= 0;
		tick(2);
	endtask
	initial begin
		tick(8);
		rst_n <= 1;
		wait_load(16'hcffe);
		`CHK({port_ab_oe, port_p_out}, 2'b00)
		apb(0, 8'h00, 0);
		`CHK(rd[7:0], 8'h00)
		apb(0, 8'h40, 0);
		`CHK({err, rd}, 33'h100000000)
		apb(1, 8'h08, 7);
		apb(0, 8'h08, 0);
		`CHK(rd[2:0], 3'h7)
		$display("register test done");
		pins(7);
		pins(0);
		apb(0, 8'h04, 0);
		`CHK(rd[7:1], 7'h0e)
		apb(1, 8'h04, 32'h1c);
		apb(0, 8'h04, 0);
		`CHK(rd[7:1], 7'h0e)
		apb(1, 8'h04, 32'h18);
		apb(0, 8'h04, 0);
		`CHK(rd[7:1], 7'h0c)
		apb(1, 8'h08, 0);
		pins(7);
		apb(0, 8'h04, 0);
		`CHK(rd[7:1], 7'h0c)
		pins(0);
		apb(0, 8'h04, 0);
		`CHK(rd[7:1], 7'h0e)
		timer_ovf <= 1;
		shared_ext_uart_irq_pin <= 0;
		tick(4);
		timer_ovf <= 0;
		apb(0, 8'h04, 0);
		`CHK(rd[6:5], 2'h3)
		shared_ext_uart_irq_pin <= 1;
		tick(4);
		apb(1, 8'h04, 0);
		apb(0, 8'h04, 0);
		`CHK(rd[7:1], 7'h00)
		// UART request reaches the shared vector only when enabled
		uart_irq <= 1;
		tick(2);
		apb(0, 8'h04, 0);
		`CHK(rd[6], 1'b0)
		uart_rx_irq_enable <= 1;
		tick(2);
		apb(0, 8'h04, 0);
		`CHK(rd[6], 1'b1)
		{uart_rx_irq_enable, uart_tx_irq_enable} <= 2'b01;
		apb(1, 8'h04, 0);
		apb(0, 8'h04, 0);
		`CHK(rd[6], 1'b1)
		{uart_irq, uart_tx_irq_enable} <= 2'b00;
		apb(1, 8'h04, 0);
		apb(0, 8'h04, 0);
		`CHK(rd[7:1], 7'h00)
		$display("pending test done");
		// Idle level of each mode is its low bit: rise, fall, high, low
		for (int m = 0; m < 4; m++) begin
			configurable_irq_pin <= m[0];
			apb(1, 8'h0c, m);
			tick(4);
			apb(1, 8'h04, 0);
			apb(0, 8'h04, 0);
			`CHK(rd[7], 1'b0)
			configurable_irq_pin <= !m[0];
			tick(4);
			apb(0, 8'h04, 0);
			`CHK(rd[7], 1'b1)
			configurable_irq_pin <= m[0];
			tick(4);
		end
		apb(1, 8'h04, 0);
		$display("config pin test done");
		apb(1, 8'h08, 7);
		apb(1, 8'h00, 32'h1c);
		instr_done <= 1;
		pins(3'h6);
		pins(0);
		`CHK(loads, 1)
		instr_done <= 0;
		apb(1, 8'h00, 32'h1d);
		tick(10);
		`CHK(loads, 1)
		instr_done <= 1;
		wait_load(16'hcffa);
		apb(0, 8'h00, 0);
		`CHK(rd[7:0], 8'h1c)
		apb(0, 8'h10, 0);
		`CHK(rd[0], 1'b1)
		apb(0, 8'h14, 0);
		`CHK(rd[15:0], 16'h0102)
		`CHK(last_push, 16'h0100)
		apb(0, 8'h04, 0);
		`CHK(rd[3:2], 2'b10)
		slow <= 1;
		pop(1);
		`CHK(last_pop, 16'h0100)
		wait_load(16'hcff8);
		pop(0);
		apb(0, 8'h00, 0);
		`CHK(rd[7:0], 8'h1c)
		apb(0, 8'h14, 0);
		`CHK(rd[15:0], 16'h0100)
		$display("service test done");
		low_power <= 1;
		pin_one_irq <= 1;
		tick(10);
		`CHK(loads, 3)
		low_power <= 0;
		wait_load(16'hcffc);
		pin_one_irq <= 0;
		pop(0);
		reset_req_n <= 0;
		instr_done <= 0;
		tick(4);
		`CHK(reset_take, 1'b1)
		reset_req_n <= 1;
		wait_load(16'hcffe);
		apb(0, 8'h14, 0);
		`CHK(rd[15:0], 16'h0100)
		$display("reset test done");
		finish_test();
	end
endmodule
